// [wd_supervision_consts.vh]
// Purpose: Constants for the slave watchdog and state supervision block
// Assumes: 16-bit register port addressed by byte offset
// Notes:   Definitions only
`ifndef WD_SUPERVISION_CONSTS_VH
`define WD_SUPERVISION_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define STATE_REQ_ADDR   16'h0120
`define STATE_STAT_ADDR  16'h0130
`define TICK_MULT_ADDR   16'h0400
`define PI_WD_TIME_ADDR  16'h0410
`define CH_WD_TIME_ADDR  16'h0420
`define WD_STAT_ADDR     16'h0440
`define SAFE_VALUE_ADDR  16'h0450
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TICK_MULT_RST    16'h09c2
`define CH_WD_TIME_RST   16'h03e8
`define PI_WD_TIME_RST   16'h03e8
`define SAFE_VALUE_RST   8'h00
`define STATE_REQ_RST    4'h1
// ----------------------------------------
// State request and status codes
// ----------------------------------------
`define CODE_INIT        4'h1
`define CODE_PREOP       4'h2
`define CODE_BOOT        4'h3
`define CODE_SAFEOP      4'h4
`define CODE_OP          4'h8
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define STAT_ERR_BIT     4
`define WD_CH_EXP_BIT    0
`define WD_PI_EXP_BIT    1
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS    100
`define BASE_TICK_NS     40
`define BASE_TICK_CYC \
  ((`BASE_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WD_TICK_EXTRA    16'h0002
`endif

// [wd_supervision.v]
// Purpose: Watchdogs and slave state machine of a fieldbus slave
// Assumes: Access events and config checks arrive on clk_in
// Notes:   Base tick is rounded up to whole clk_in cycles
`default_nettype none
`include "wd_supervision_consts.vh"

module wd_supervision (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_n_in,
  // Register port
  input  wire [15:0] reg_addr_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [15:0] reg_wdata_in,
  output reg  [15:0] reg_rdata_out,
  output reg         reg_rvalid_out,
  // Traffic events
  input  wire        pd_access_in,
  input  wire        pi_access_in,
  // Configuration checks
  input  wire        mbx_cfg_ok_in,
  input  wire        pd_cfg_ok_in,
  input  wire        clk_cfg_ok_in,
  input  wire        input_copy_done_in,
  // Output data
  input  wire [7:0]  master_data_in,
  output reg  [7:0]  out_data_out,
  // Traffic permissions and status
  output reg         mbx_allow_out,
  output reg         foe_only_out,
  output reg         pd_allow_out,
  output reg         input_update_out,
  output reg         input_copy_out,
  output reg         ch_expired_out,
  output reg         pi_expired_out,
  output reg  [3:0]  state_out
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [5:0] ST_INIT   = 6'h01;
  localparam [5:0] ST_PREOP  = 6'h02;
  localparam [5:0] ST_COPY   = 6'h04;
  localparam [5:0] ST_SAFEOP = 6'h08;
  localparam [5:0] ST_OP     = 6'h10;
  localparam [5:0] ST_BOOT   = 6'h20;
  localparam integer BASE_CYC_INT = `BASE_TICK_CYC;
  localparam [15:0]  BASE_CYC     = BASE_CYC_INT[15:0];
  function wd_due;
    input [15:0] cnt, lim;
    begin
      wd_due = (lim != 16'h0000) && (cnt >= lim);
    end
  endfunction
  function [15:0] rd_mux;
    input [15:0] a, mult, pit, cht, st, wds, sv;
    begin
      case (a)
        `STATE_STAT_ADDR: rd_mux = st;
        `TICK_MULT_ADDR:  rd_mux = mult;
        `PI_WD_TIME_ADDR: rd_mux = pit;
        `CH_WD_TIME_ADDR: rd_mux = cht;
        `WD_STAT_ADDR:    rd_mux = wds;
        `SAFE_VALUE_ADDR: rd_mux = sv;
        default:          rd_mux = 16'h0000;
      endcase
    end
  endfunction
  reg [15:0] mult_reg;
  reg [15:0] pi_time_reg;
  reg [15:0] ch_time_reg;
  reg [7:0]  safe_reg;
  reg [3:0]  req_reg;
  reg        req_new_reg;
  reg        err_reg;
  reg [5:0]  state_reg;
  reg [5:0]  state_next;
  reg [15:0] base_cnt_reg;
  reg [15:0] tick_cnt_reg;
  reg        tick_reg;
  reg [15:0] ch_cnt_reg;
  reg [15:0] pi_cnt_reg;
  reg        ch_exp_reg;
  reg        pi_exp_reg;
  reg [3:0]  code_next;
  reg        err_next;

  wire [15:0] tick_len = mult_reg + `WD_TICK_EXTRA;
  wire wr_req = reg_wr_in && (reg_addr_in == `STATE_REQ_ADDR);
  wire ch_off = (ch_time_reg == 16'h0000);
  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Untouched registers keep their contents; no implicit reload.
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      mult_reg    <= `TICK_MULT_RST;
      ch_time_reg <= `CH_WD_TIME_RST;
      pi_time_reg <= `PI_WD_TIME_RST;
      safe_reg    <= `SAFE_VALUE_RST;
      req_reg     <= `STATE_REQ_RST;
      req_new_reg <= 1'b0;
    end else begin
      req_new_reg <= wr_req;
      if (wr_req)
        req_reg <= reg_wdata_in[3:0];
      if (reg_wr_in) begin
        case (reg_addr_in)
          `TICK_MULT_ADDR:  mult_reg <= reg_wdata_in;
          `PI_WD_TIME_ADDR: pi_time_reg <= reg_wdata_in;
          `CH_WD_TIME_ADDR: ch_time_reg <= reg_wdata_in;
          `SAFE_VALUE_ADDR: safe_reg <= reg_wdata_in[7:0];
          default: ;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out  <= 16'h0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= rd_mux(reg_addr_in, mult_reg, pi_time_reg, ch_time_reg,
                                {11'h000, err_reg, state_out},
                                {14'h0000, pi_exp_reg, ch_exp_reg},
                                {8'h00, safe_reg});
    end
  end
  // ----------------------------------------
  // Shared tick prescaler
  // ----------------------------------------
  // Free running, so a rearm may lose up to one tick of margin.
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      base_cnt_reg <= 16'h0000;
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (base_cnt_reg >= BASE_CYC - 16'h0001) begin
        base_cnt_reg <= 16'h0000;
        if (tick_cnt_reg >= tick_len - 16'h0001) begin
          tick_cnt_reg <= 16'h0000;
          tick_reg     <= 1'b1;
        end else begin
          tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
      end else begin
        base_cnt_reg <= base_cnt_reg + 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // Watchdogs
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      ch_cnt_reg <= 16'h0000;
      pi_cnt_reg <= 16'h0000;
      ch_exp_reg <= 1'b0;
      pi_exp_reg <= 1'b0;
    end else begin
      if (pd_access_in) begin
        ch_cnt_reg <= 16'h0000;
        ch_exp_reg <= 1'b0;
      end else if (ch_off) begin
        ch_cnt_reg <= 16'h0000;
        ch_exp_reg <= 1'b0;
      end else if (wd_due(ch_cnt_reg, ch_time_reg)) begin
        ch_exp_reg <= 1'b1;
      end else if (tick_reg) begin
        ch_cnt_reg <= ch_cnt_reg + 16'h0001;
      end
      if (pi_access_in) begin
        pi_cnt_reg <= 16'h0000;
        pi_exp_reg <= 1'b0;
      end else if (pi_time_reg == 16'h0000) begin
        pi_cnt_reg <= 16'h0000;
        pi_exp_reg <= 1'b0;
      end else if (wd_due(pi_cnt_reg, pi_time_reg)) begin
        pi_exp_reg <= 1'b1;
      end else if (tick_reg) begin
        pi_cnt_reg <= pi_cnt_reg + 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // Slave state machine
  // ----------------------------------------
  // Watchdog expiry is not an input here, so it cannot move the state.
  always @* begin
    state_next = state_reg;
    err_next   = err_reg;
    case (state_reg)
      ST_INIT: begin
        if (req_new_reg) begin
          if (req_reg == `CODE_PREOP) begin
            state_next = mbx_cfg_ok_in ? ST_PREOP : ST_INIT;
            err_next   = !mbx_cfg_ok_in;
          end else if (req_reg == `CODE_BOOT) begin
            state_next = ST_BOOT;
            err_next   = 1'b0;
          end else begin
            err_next = (req_reg != `CODE_INIT);
          end
        end
      end
      ST_PREOP: begin
        if (req_new_reg) begin
          if (req_reg == `CODE_SAFEOP) begin
            state_next = (pd_cfg_ok_in && clk_cfg_ok_in) ? ST_COPY : ST_PREOP;
            err_next   = !(pd_cfg_ok_in && clk_cfg_ok_in);
          end else if (req_reg == `CODE_INIT) begin
            state_next = ST_INIT;
            err_next   = 1'b0;
          end else begin
            err_next = (req_reg != `CODE_PREOP);
          end
        end
      end
      ST_COPY: begin
        if (input_copy_done_in)
          state_next = ST_SAFEOP;
      end
      ST_SAFEOP, ST_OP: begin
        if (req_new_reg) begin
          err_next = 1'b0;
          case (req_reg)
            `CODE_INIT:   state_next = ST_INIT;
            `CODE_PREOP:  state_next = ST_PREOP;
            `CODE_SAFEOP: state_next = ST_SAFEOP;
            `CODE_OP:     state_next = ST_OP;
            default:      err_next = 1'b1;
          endcase
        end
      end
      ST_BOOT: begin
        if (req_new_reg) begin
          state_next = (req_reg == `CODE_INIT) ? ST_INIT : ST_BOOT;
          err_next   = (req_reg != `CODE_INIT) && (req_reg != `CODE_BOOT);
        end
      end
      default: begin
        state_next = ST_INIT;
        err_next   = 1'b1;
      end
    endcase
  end

  always @* begin
    case (state_next)
      ST_PREOP, ST_COPY: code_next = `CODE_PREOP;
      ST_SAFEOP: code_next = `CODE_SAFEOP;
      ST_OP:     code_next = `CODE_OP;
      ST_BOOT:   code_next = `CODE_BOOT;
      default:   code_next = `CODE_INIT;
    endcase
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_INIT;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      err_reg   <= err_next;
    end
  end
  // ----------------------------------------
  // Permissions and outputs
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      mbx_allow_out    <= 1'b0;
      foe_only_out     <= 1'b0;
      pd_allow_out     <= 1'b0;
      input_update_out <= 1'b0;
      input_copy_out   <= 1'b0;
      ch_expired_out   <= 1'b0;
      pi_expired_out   <= 1'b0;
      out_data_out     <= `SAFE_VALUE_RST;
      state_out        <= `CODE_INIT;
    end else begin
      state_out        <= code_next;
      ch_expired_out   <= ch_exp_reg;
      pi_expired_out   <= pi_exp_reg;
      mbx_allow_out    <= (state_next != ST_INIT);
      foe_only_out     <= (state_next == ST_BOOT);
      pd_allow_out     <= (state_next == ST_SAFEOP) ||
                          (state_next == ST_OP);
      input_update_out <= (state_next == ST_SAFEOP) ||
                          (state_next == ST_OP);
      input_copy_out   <= (state_next == ST_COPY);
      if (ch_exp_reg || pi_exp_reg)
        out_data_out <= safe_reg;
      else if (state_next == ST_OP)
        out_data_out <= master_data_in;
      else if (state_next == ST_SAFEOP && ch_off)
        out_data_out <= master_data_in;
      else
        out_data_out <= safe_reg;
    end
  end

endmodule // wd_supervision
`default_nettype wire

// [wd_supervision_checker.sv]
// Purpose: Port checker for the watchdog and state supervision block
// Assumes: Bound to the top module, one clock domain
// Notes:   Safe value is not tracked here, the bench compares it
`default_nettype none
`include "wd_supervision_consts.vh"
module wd_supervision_checker (
  // Clock, reset and inputs
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  input wire logic       reg_rd_in,
  input wire logic       pd_access_in,
  input wire logic [7:0] master_data_in,
  // Outputs watched
  input wire logic       reg_rvalid_out,
  input wire logic [7:0] out_data_out,
  input wire logic       mbx_allow_out,
  input wire logic       foe_only_out,
  input wire logic       pd_allow_out,
  input wire logic       input_update_out,
  input wire logic       input_copy_out,
  input wire logic       ch_expired_out,
  input wire logic       pi_expired_out,
  input wire logic [3:0] state_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_READ_ANSWER: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read got no answer");
  AST_INIT_SILENT: assert property (state_out == `CODE_INIT |-> !mbx_allow_out && !pd_allow_out)
    else $error("traffic allowed in init");
  AST_PREOP_MAILBOX: assert property (state_out == `CODE_PREOP && !input_copy_out
    |-> mbx_allow_out && !pd_allow_out) else $error("preop permissions wrong");
  AST_SAFEOP_TRAFFIC: assert property (state_out == `CODE_SAFEOP
    |-> mbx_allow_out && pd_allow_out && input_update_out) else $error("safeop traffic off");
  AST_BOOT_FILE_ONLY: assert property (state_out == `CODE_BOOT |-> foe_only_out && !pd_allow_out)
    else $error("boot permissions wrong");
  AST_BOOT_ENTRY: assert property ($rose(foe_only_out) |-> $past(state_out) == `CODE_INIT)
    else $error("boot entered from a state other than init");
  AST_EXPIRY_KEEPS_STATE: assert property ($rose(ch_expired_out) |-> $stable(state_out))
    else $error("channel expiry changed state");
  AST_OP_COPY: assert property (state_out == `CODE_OP && !ch_expired_out && !pi_expired_out
    |-> out_data_out == $past(master_data_in)) else $error("op outputs not master data");
  AST_REARM: assert property (pd_access_in |-> ##2 !ch_expired_out)
    else $error("access did not rearm channel watchdog");
  cover property (state_out == `CODE_OP && ch_expired_out);
  cover property ($fell(input_copy_out));
  cover property (foe_only_out);
endmodule // wd_supervision_checker
`default_nettype wire

// [wd_far_side.sv]
// Purpose: Far side model, fieldbus master accesses and local processor
// Assumes: Pulses launched on the falling edge
// Notes:   An access every other cycle keeps a two-cycle tick armed
`default_nettype none
module wd_far_side #(
  parameter int COPY_DELAY = 3
) (
  // Clock and run controls
  input  wire logic clk_in,
  input  wire logic pd_run_in,
  input  wire logic pi_run_in,
  input  wire logic copy_req_in,
  // Events towards the block
  output var logic  pd_access_out,
  output var logic  pi_access_out,
  output var logic  copy_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int copy_cnt;
  initial begin
    pd_access_out = 1'b0;
    pi_access_out = 1'b0;
    copy_done_out = 1'b0;
    copy_cnt      = 0;
  end
  // Slow copy, so the copy phase is visible at the ports
  always @(negedge clk_in) begin
    pd_access_out <= pd_run_in && !pd_access_out;
    pi_access_out <= pi_run_in && !pi_access_out;
    copy_cnt      <= copy_req_in ? copy_cnt + 1 : 0;
    copy_done_out <= copy_req_in && copy_cnt >= COPY_DELAY;
  end
endmodule // wd_far_side
`default_nettype wire

// [wd_supervision_bench.sv]
// Purpose: Self-checking bench for the watchdog and state supervision block
// Assumes: Multiplier 0 and timer 4 make a watchdog expire within a few cycles
// Notes:   Inputs change on the falling clock edge only
`default_nettype none
`include "wd_supervision_consts.vh"
module wd_supervision_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in         = 1'b0;
  logic        reset_n_in     = 1'b0;
  logic [15:0] reg_addr_in    = 16'h0000;
  logic        reg_wr_in      = 1'b0;
  logic        reg_rd_in      = 1'b0;
  logic [15:0] reg_wdata_in   = 16'h0000;
  logic        mbx_cfg_ok_in  = 1'b0;
  logic        pd_cfg_ok_in   = 1'b0;
  logic        clk_cfg_ok_in  = 1'b0;
  logic [7:0]  master_data_in = 8'h00;
  logic        pd_run         = 1'b0;
  logic        pi_run         = 1'b0;
  logic [15:0] reg_rdata_out;
  logic [7:0]  out_data_out;
  logic [3:0]  state_out;
  logic        reg_rvalid_out, pd_access_in, pi_access_in, input_copy_done_in;
  logic        mbx_allow_out, foe_only_out, pd_allow_out, input_update_out;
  logic        input_copy_out, ch_expired_out, pi_expired_out;
  int          miscompares    = 0;
  int          check_count    = 0;
  int          waited         = 0;
  wire [2:0]   flags          = {state_out == `CODE_SAFEOP, pi_expired_out, ch_expired_out};

  wd_supervision u_dut (.clk_in, .reset_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .pd_access_in, .pi_access_in,
    .mbx_cfg_ok_in, .pd_cfg_ok_in, .clk_cfg_ok_in, .input_copy_done_in, .master_data_in,
    .out_data_out, .mbx_allow_out, .foe_only_out, .pd_allow_out, .input_update_out,
    .input_copy_out, .ch_expired_out, .pi_expired_out, .state_out);
  wd_far_side u_far (.clk_in, .pd_run_in(pd_run), .pi_run_in(pi_run),
    .copy_req_in(input_copy_out), .pd_access_out(pd_access_in),
    .pi_access_out(pi_access_in), .copy_done_out(input_copy_done_in));

  initial forever #50 clk_in = ~clk_in;

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chkb(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic test_done();
    $display("Compares %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_in);
    reg_addr_in  = a;
    reg_wdata_in = d;
    reg_wr_in    = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in   = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    chkb(reg_rvalid_out, 1'b1);
    chk(reg_rdata_out, exp);
  endtask
  // State changes land one edge after the write edge
  task automatic req(input logic [3:0] code, input logic [3:0] exp);
    wr(`STATE_REQ_ADDR, {12'h000, code});
    repeat (3) @(negedge clk_in);
    chk({12'h000, state_out}, {12'h000, exp});
  endtask
  task automatic wait_flag(input int idx, input logic val);
    int n;
    for (n = 0; n < 200 && flags[idx] !== val; n++) @(negedge clk_in);
    waited = n;
    if (flags[idx] !== val) begin
      chkb(flags[idx], val);
      test_done();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge clk_in);
    reset_n_in = 1'b1;
    chk({12'h000, state_out}, 16'h0001);
    rd(`TICK_MULT_ADDR, `TICK_MULT_RST);
    rd(`CH_WD_TIME_ADDR, `CH_WD_TIME_RST);
    rd(16'h0500, 16'h0000);
    wr(`PI_WD_TIME_ADDR, 16'hffff);
    rd(`PI_WD_TIME_ADDR, 16'hffff);
    wr(`TICK_MULT_ADDR, 16'h0000);
    rd(`TICK_MULT_ADDR, 16'h0000);
    wr(`CH_WD_TIME_ADDR, 16'h0004);
    wr(`PI_WD_TIME_ADDR, 16'h0004);
    rd(`CH_WD_TIME_ADDR, 16'h0004);
    wr(`SAFE_VALUE_ADDR, 16'h003c);
    req(`CODE_PREOP, `CODE_INIT);
    rd(`STATE_STAT_ADDR, 16'h0011);
    mbx_cfg_ok_in = 1'b1;
    req(`CODE_OP, `CODE_INIT);
    req(`CODE_PREOP, `CODE_PREOP);
    chkb(mbx_allow_out, 1'b1);
    req(`CODE_BOOT, `CODE_PREOP);
    req(`CODE_OP, `CODE_PREOP);
    pd_cfg_ok_in = 1'b1;
    req(`CODE_SAFEOP, `CODE_PREOP);
    chkb(input_copy_out, 1'b0);
    clk_cfg_ok_in = 1'b1;
    req(`CODE_SAFEOP, `CODE_PREOP);
    chkb(input_copy_out, 1'b1);
    chkb(pd_allow_out, 1'b0);
    wait_flag(2, 1'b1);
    master_data_in = 8'h5a;
    pd_run = 1'b1;
    pi_run = 1'b1;
    wait_flag(0, 1'b0);
    wait_flag(1, 1'b0);
    chk({8'h00, out_data_out}, 16'h003c);
    req(`CODE_OP, `CODE_OP);
    chk({8'h00, out_data_out}, 16'h005a);
    pd_run = 1'b0;
    wait_flag(0, 1'b1);
    // Timer 4 times (0 + 2) is 8 cycles, plus one tick of phase and two register stages
    chkb(waited >= 8 && waited <= 12, 1'b1);
    chk({8'h00, out_data_out}, 16'h003c);
    chk({12'h000, state_out}, 16'h0008);
    rd(`WD_STAT_ADDR, 16'h0001);
    pd_run = 1'b1;
    wait_flag(0, 1'b0);
    pi_run = 1'b0;
    wait_flag(1, 1'b1);
    chk({8'h00, out_data_out}, 16'h003c);
    rd(`WD_STAT_ADDR, 16'h0002);
    pi_run = 1'b1;
    wait_flag(1, 1'b0);
    wr(`CH_WD_TIME_ADDR, 16'h0000);
    wr(`PI_WD_TIME_ADDR, 16'h0000);
    pd_run = 1'b0;
    pi_run = 1'b0;
    repeat (40) @(negedge clk_in);
    chkb(ch_expired_out, 1'b0);
    chk({8'h00, out_data_out}, 16'h005a);
    req(`CODE_SAFEOP, `CODE_SAFEOP);
    chk({8'h00, out_data_out}, 16'h005a);
    req(`CODE_PREOP, `CODE_PREOP);
    req(`CODE_INIT, `CODE_INIT);
    req(`CODE_BOOT, `CODE_BOOT);
    chkb(foe_only_out, 1'b1);
    req(`CODE_PREOP, `CODE_BOOT);
    test_done();
  end
endmodule // wd_supervision_bench

bind wd_supervision wd_supervision_checker u_chk (.clk_in, .reset_n_in, .reg_rd_in,
  .pd_access_in, .master_data_in, .reg_rvalid_out, .out_data_out, .mbx_allow_out,
  .foe_only_out, .pd_allow_out, .input_update_out, .input_copy_out, .ch_expired_out,
  .pi_expired_out, .state_out);
`default_nettype wire
